// ### debug_link_defs.svh
// constants of the two-wire debug link register access block
`ifndef DEBUG_LINK_DEFS_SVH
`define DEBUG_LINK_DEFS_SVH
// ============================================================
// link register select values
`define SEL_DEVICE_IDENTITY   8'h00
`define SEL_REVISION_IDENTITY 8'h01
`define SEL_FLASH_CONTROL     8'h02
`define SEL_FLASH_DATA        8'hB4
// ============================================================
// reset values, and the value a read of an unassigned select returns
`define SELECT_RESET          8'h00
`define CONTROL_RESET         8'h00
`define UNMAPPED_READ         8'h00
// idle pin levels after reset: [1] data line pulled high, [0] link clock low
`define LINK_PIN_IDLE         2'b10
// ============================================================
// flash unlock codes, written in this order
`define UNLOCK_FIRST          8'h02
`define UNLOCK_SECOND         8'h01
// ============================================================
// flash command codes
`define FLASH_CMD_BLOCK_READ  8'h06
`define FLASH_CMD_BLOCK_WRITE 8'h07
`define FLASH_CMD_PAGE_ERASE  8'h08
`define FLASH_CMD_DEVICE_ERASE 8'h03
// ============================================================
// frame layout
`define FRAME_START_LEVEL     1'b0
`define INSTR_BITS            2
`define BYTE_LAST_BIT         3'h7
`endif

// ### debug_link_host.sv
// host adapter model that drives the two-wire debug link
`timescale 1ns/1ps
// ====
// host side of the link
module debug_link_host (
	// system clock, used only as a time base
	input  wire logic i_clk,
	// resolved data line level
	input  wire logic i_wire,
	// link pins driven by the host
	output logic      o_link_clock,
	output logic      o_drive,
	output logic      o_drive_oe
);
	// idle: clock stands low, line released to its pull-up
	initial begin
		o_link_clock = 1'b0;
		o_drive = 1'b1;
		o_drive_oe = 1'b0;
	end
	// one bit: change while clock low, sample just before the rise
	task automatic send_bit(input logic v, input logic drv, output logic seen);
		@(negedge i_clk);
		o_link_clock = 1'b0;
		o_drive_oe = drv;
		o_drive = v;
		repeat (4) @(negedge i_clk);
		seen = i_wire;
		o_link_clock = 1'b1;
		repeat (3) @(negedge i_clk);
	endtask
	// whole frame; registers are only reachable this way
	task automatic frame(input logic [1:0] ins, input logic [7:0] wv, output logic [7:0] rv);
		logic s;
		// gap lets the device drop its drive after a read
		repeat (8) @(negedge i_clk);
		send_bit(1'b0, 1'b1, s);
		send_bit(ins[0], 1'b1, s);
		send_bit(ins[1], 1'b1, s);
		for (int i = 0; i < 8; i++) begin
			send_bit(wv[i], ins[0], s);
			rv[i] = s;
		end
		@(negedge i_clk);
		o_link_clock = 1'b0;
		o_drive_oe = 1'b0;
	endtask
endmodule

// ### debug_link_pkg.sv
// types of the two-wire debug link register access block
package debug_link_pkg;
	// link instruction codes carried after the start bit
	typedef enum logic [1:0] {
		INSTR_DATA_READ  = 2'h0,
		INSTR_DATA_WRITE = 2'h1,
		INSTR_ADDR_READ  = 2'h2,
		INSTR_ADDR_WRITE = 2'h3
	} link_instr_t;
	// frame sequencer states
	typedef enum {
		ST_IDLE,
		ST_INSTR,
		ST_WDATA,
		ST_RDATA
	} link_state_t;
	// flash engine write carrier
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} flash_write_t;
endpackage

// ### debug_link_regs.sv
// two-wire debug link: frame decoder and link-reached register file
`timescale 1ns/1ps
`include "debug_link_defs.svh"
// ============================================================
module debug_link_regs
	import debug_link_pkg::*;
#(
	parameter logic [7:0] DEVICE_ID   = 8'h5A, // arbitrary value
	parameter logic [7:0] REVISION_ID = 8'h3C, // arbitrary value
	parameter int         SYNC_DEPTH  = 3
) (
	// clock, reset, enable
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	input  wire logic         i_ce,
	// debug link pins, the only way in
	input  wire logic         i_debug_link_clock,
	input  wire logic         i_debug_link_data,
	output logic              o_debug_link_data,
	output logic              o_debug_link_data_oe,
	// flash engine side
	input  wire logic [7:0]   i_flash_rd_data,
	output flash_write_t      o_flash_write,
	output logic              o_flash_prog_enable
);
	// ============================================================
	// elaboration check
	if (SYNC_DEPTH != 3) begin : g_bad_depth
		$error("SYNC_DEPTH must be 3");
	end

	// ============================================================
	// pin synchronisers: [0] link clock, [1] link data
	logic [2:0] sync_reg [2];
	logic [2:0] sync_next [2];
	logic       level_reg [2];
	logic       level_next [2];
	// reset to the idle levels so that no false edge follows reset
	localparam logic [1:0] PIN_IDLE = `LINK_PIN_IDLE;

	// each pin passes three flops; a change counts once stages two and three agree
	for (genvar g = 0; g < 2; g++) begin : g_sync
		always_comb begin
			sync_next[g] = {sync_reg[g][1:0], (g == 0) ? i_debug_link_clock : i_debug_link_data};
			level_next[g] = (sync_reg[g][1] == sync_reg[g][2]) ? sync_reg[g][2] : level_reg[g];
		end
		always_ff @(posedge i_clk) begin
			if (i_rst) begin
				sync_reg[g]  <= {3{PIN_IDLE[g]}};
				level_reg[g] <= PIN_IDLE[g];
			end else if (i_ce) begin
				sync_reg[g]  <= sync_next[g];
				level_reg[g] <= level_next[g];
			end
		end
	end

	logic link_rise;
	logic link_bit;
	assign link_rise = level_next[0] && !level_reg[0];
	assign link_bit  = level_reg[1];

	// ============================================================
	// frame sequencer and registers
	link_state_t  state_reg, state_next;
	link_instr_t  instr_reg, instr_next;
	logic [2:0]   cnt_reg, cnt_next;
	logic [7:0]   shift_reg, shift_next;
	logic [7:0]   link_register_select_reg, link_register_select_next;
	logic [7:0]   flash_program_control_reg, flash_program_control_next;
	logic         unlock_stage_reg, unlock_stage_next;
	logic         prog_en_reg, prog_en_next;
	flash_write_t flash_write_reg, flash_write_next;
	logic         dq_out_reg, dq_out_next;
	logic         dq_oe_reg, dq_oe_next;
	logic [7:0]   read_value;
	logic [7:0]   wbyte;

	// read mux: what a data read returns for the current select
	always_comb begin
		unique case (link_register_select_reg)
			`SEL_DEVICE_IDENTITY:   read_value = DEVICE_ID;
			`SEL_REVISION_IDENTITY: read_value = REVISION_ID;
			`SEL_FLASH_CONTROL:     read_value = flash_program_control_reg;
			`SEL_FLASH_DATA:        read_value = i_flash_rd_data;
			default:                read_value = `UNMAPPED_READ;
		endcase
	end

	// next state: bits taken on each filtered rise of the link clock
	always_comb begin
		state_next                 = state_reg;
		instr_next                 = instr_reg;
		cnt_next                   = cnt_reg;
		shift_next                 = shift_reg;
		link_register_select_next  = link_register_select_reg;
		flash_program_control_next = flash_program_control_reg;
		unlock_stage_next          = unlock_stage_reg;
		prog_en_next               = prog_en_reg;
		flash_write_next           = '0; // strobe lasts one cycle
		dq_out_next                = dq_out_reg;
		dq_oe_next                 = dq_oe_reg;
		wbyte                      = {link_bit, shift_reg[7:1]};
		if (link_rise) begin
			unique case (state_reg)
				ST_IDLE: begin
					if (link_bit == `FRAME_START_LEVEL) begin
						state_next = ST_INSTR;
						cnt_next   = 3'h0;
					end
				end
				ST_INSTR: begin
					instr_next = link_instr_t'({link_bit, instr_reg[1]});
					cnt_next   = cnt_reg + 3'h1;
					if (cnt_reg == 3'(`INSTR_BITS - 1)) begin
						cnt_next = 3'h0;
						// bit 0, now in instr_reg[1], picks write; bit 1, still on the line, picks address
						if (instr_reg[1]) begin
							state_next = ST_WDATA;
						end else begin
							// read: load the byte and drive bit 0 at once
							shift_next  = link_bit ? link_register_select_reg : read_value;
							dq_out_next = link_bit ? link_register_select_reg[0] : read_value[0];
							dq_oe_next  = 1'b1;
							state_next  = ST_RDATA;
						end
					end
				end
				ST_WDATA: begin
					shift_next = wbyte;
					cnt_next   = cnt_reg + 3'h1;
					if (cnt_reg == `BYTE_LAST_BIT) begin
						state_next = ST_IDLE;
						if (instr_reg == INSTR_ADDR_WRITE) begin
							link_register_select_next = wbyte;
						end else if (link_register_select_reg == `SEL_FLASH_CONTROL) begin
							flash_program_control_next = wbyte;
							// unlock needs the two codes back to back
							unlock_stage_next = (wbyte == `UNLOCK_FIRST);
							if (unlock_stage_reg && wbyte == `UNLOCK_SECOND) begin
								prog_en_next = 1'b1;
							end
						end else if (link_register_select_reg == `SEL_FLASH_DATA && prog_en_reg) begin
							flash_write_next = '{valid: 1'b1, data: wbyte};
						end
						// identity, revision and unassigned writes fall through
					end
				end
				ST_RDATA: begin
					cnt_next    = cnt_reg + 3'h1;
					shift_next  = {1'b0, shift_reg[7:1]};
					dq_out_next = shift_reg[1];
					if (cnt_reg == `BYTE_LAST_BIT) begin
						dq_oe_next  = 1'b0; // release the line after bit 7
						dq_out_next = 1'b0;
						state_next  = ST_IDLE;
					end
				end
			endcase
		end
	end

	// register the frame state; programming enable clears only on system reset
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state_reg                 <= ST_IDLE;
			instr_reg                 <= INSTR_DATA_READ;
			cnt_reg                   <= 3'h0;
			shift_reg                 <= 8'h00;
			link_register_select_reg  <= `SELECT_RESET;
			flash_program_control_reg <= `CONTROL_RESET;
			unlock_stage_reg          <= 1'b0;
			prog_en_reg               <= 1'b0;
			flash_write_reg           <= '0;
			dq_out_reg                <= 1'b0;
			dq_oe_reg                 <= 1'b0;
		end else if (i_ce) begin
			state_reg                 <= state_next;
			instr_reg                 <= instr_next;
			cnt_reg                   <= cnt_next;
			shift_reg                 <= shift_next;
			link_register_select_reg  <= link_register_select_next;
			flash_program_control_reg <= flash_program_control_next;
			unlock_stage_reg          <= unlock_stage_next;
			prog_en_reg               <= prog_en_next;
			flash_write_reg           <= flash_write_next;
			dq_out_reg                <= dq_out_next;
			dq_oe_reg                 <= dq_oe_next;
		end
	end

	assign o_debug_link_data    = dq_out_reg;
	assign o_debug_link_data_oe = dq_oe_reg;
	assign o_flash_write        = flash_write_reg;
	assign o_flash_prog_enable  = prog_en_reg;

	// ============================================================
	// assertions
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	logic data_read_start;
	assign data_read_start = i_ce && link_rise && state_reg == ST_INSTR && cnt_reg == 3'h1
		&& !link_bit && !instr_reg[1];

	sequence s_ctl_write(logic [7:0] v);
		i_ce && link_rise && state_reg == ST_WDATA && cnt_reg == `BYTE_LAST_BIT
			&& instr_reg == INSTR_DATA_WRITE && link_register_select_reg == `SEL_FLASH_CONTROL && wbyte == v;
	endsequence

	a_select_load: assert property (i_ce && link_rise && state_reg == ST_WDATA && cnt_reg == `BYTE_LAST_BIT
		&& instr_reg == INSTR_ADDR_WRITE |=> link_register_select_reg == $past(wbyte))
		else $error("select register not loaded");
	a_read_identity: assert property (data_read_start && link_register_select_reg == `SEL_DEVICE_IDENTITY
		|=> shift_reg == DEVICE_ID && dq_oe_reg && dq_out_reg == DEVICE_ID[0])
		else $error("identity read wrong");
	a_read_revision: assert property (data_read_start && link_register_select_reg == `SEL_REVISION_IDENTITY
		|=> shift_reg == REVISION_ID)
		else $error("revision read wrong");
	a_read_control: assert property (data_read_start && link_register_select_reg == `SEL_FLASH_CONTROL
		|=> shift_reg == $past(flash_program_control_reg))
		else $error("control read wrong");
	a_read_unmapped: assert property (data_read_start && !(link_register_select_reg inside {`SEL_DEVICE_IDENTITY,
		`SEL_REVISION_IDENTITY, `SEL_FLASH_CONTROL, `SEL_FLASH_DATA}) |=> shift_reg == 8'h00)
		else $error("unmapped read not zero");
	a_unlock_arm: assert property (s_ctl_write(`UNLOCK_FIRST) |=> unlock_stage_reg)
		else $error("first unlock code not armed");
	a_unlock_order: assert property (unlock_stage_reg ##0 s_ctl_write(`UNLOCK_SECOND) |=> prog_en_reg)
		else $error("unlock did not enable programming");
	a_unlock_only: assert property (!prog_en_reg ##1 prog_en_reg
		|-> $past(unlock_stage_reg) && $past(wbyte) == `UNLOCK_SECOND)
		else $error("programming enabled without the unlock codes");
	a_enable_sticky: assert property (prog_en_reg |=> prog_en_reg)
		else $error("programming enable dropped without reset");
	a_flash_strobe: assert property (flash_write_reg.valid |-> prog_en_reg
		&& $past(link_register_select_reg) == `SEL_FLASH_DATA ##1 !flash_write_reg.valid)
		else $error("flash write strobe wrong");
	a_drive_only_read: assert property (dq_oe_reg |-> state_reg == ST_RDATA)
		else $error("data line driven outside a read");
endmodule

// ### debug_link_regs_tb_top.sv
// self-checking bench for the debug link register access block
`timescale 1ns/1ps
`include "debug_link_defs.svh"
module debug_link_regs_tb_top;
	import debug_link_pkg::*;
	// ====
	// signals and model state
	localparam logic [7:0] ID  = 8'hA7; // arbitrary value
	localparam logic [7:0] REV = 8'h4D; // arbitrary value
	logic         clk, rst, lclk, hval, hoe, wire_lvl, dout, doe, pen;
	logic [7:0]   frd, sel, ctl, v, s, e;
	logic         armed, en, ce;
	flash_write_t fw;
	logic [7:0]   exp_q[$], got_q[$];
	logic [7:0]   cmds[4] = '{`FLASH_CMD_BLOCK_READ, `FLASH_CMD_BLOCK_WRITE,
		`FLASH_CMD_PAGE_ERASE, `FLASH_CMD_DEVICE_ERASE};
	integer       failures = 0, checks = 0, seed = 53238;
	// device drive wins, else host, else pull-up
	assign wire_lvl = doe ? dout : (hoe ? hval : 1'b1);
	debug_link_regs #(.DEVICE_ID(ID), .REVISION_ID(REV), .SYNC_DEPTH(3)) DUT (.i_clk(clk),
		.i_rst(rst), .i_ce(ce), .i_debug_link_clock(lclk), .i_debug_link_data(wire_lvl),
		.o_debug_link_data(dout), .o_debug_link_data_oe(doe), .i_flash_rd_data(frd),
		.o_flash_write(fw), .o_flash_prog_enable(pen));
	debug_link_host host (.i_clk(clk), .i_wire(wire_lvl), .o_link_clock(lclk),
		.o_drive(hval), .o_drive_oe(hoe));
	// clock and flash strobe capture
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) if (fw.valid === 1'b1) got_q.push_back(fw.data);
	// ====
	// tasks
	task automatic summarize();
		$display("checks=%0d failures=%0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic do_reset();
		@(negedge clk) rst = 1'b1;
		repeat (20) @(negedge clk);
		rst = 1'b0;
		{sel, ctl, armed, en} = 18'h0;
	endtask
	task automatic set_sel(input logic [7:0] x);
		logic [7:0] r;
		host.frame(INSTR_ADDR_WRITE, x, r);
		sel = x;
		host.frame(INSTR_ADDR_READ, 8'h00, r);
		check(r, x);
	endtask
	// model of a data write: unlock needs 0x02 then directly 0x01
	task automatic wr(input logic [7:0] x);
		logic [7:0] r;
		host.frame(INSTR_DATA_WRITE, x, r);
		if (sel == `SEL_FLASH_CONTROL) begin
			en = en | (armed & (x == `UNLOCK_SECOND));
			armed = (x == `UNLOCK_FIRST);
			ctl = x;
		end
		if (sel == `SEL_FLASH_DATA && en) exp_q.push_back(x);
		repeat (4) @(negedge clk);
		check({7'h00, pen}, {7'h00, en});
	endtask
	task automatic rd(output logic [7:0] seen, output logic [7:0] exp);
		frd = 8'($random(seed));
		case (sel)
			`SEL_DEVICE_IDENTITY:   exp = ID;
			`SEL_REVISION_IDENTITY: exp = REV;
			`SEL_FLASH_CONTROL:     exp = ctl;
			`SEL_FLASH_DATA:        exp = frd;
			default:                exp = `UNMAPPED_READ;
		endcase
		host.frame(INSTR_DATA_READ, 8'h00, seen);
	endtask
	// ====
	// watchdog, far beyond the ~3700 cycles the tests take
	initial begin
		#1000000;
		failures++;
		summarize();
	end
	// ====
	// main sequence
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		frd = 8'h00;
		do_reset();
		set_sel(`SEL_DEVICE_IDENTITY);
		rd(s, e); check(s, e);
		wr(8'hFF);
		rd(s, e); check(s, e);
		set_sel(`SEL_REVISION_IDENTITY);
		rd(s, e); check(s, e);
		$display("test identity done");
		// control readback, then an unlock broken by a stray write
		set_sel(`SEL_FLASH_CONTROL);
		v = 8'($random(seed));
		wr(v);
		rd(s, e); check(s, e);
		wr(`UNLOCK_FIRST);
		wr(8'h05);
		wr(`UNLOCK_SECOND);
		set_sel(`SEL_FLASH_DATA);
		wr(`FLASH_CMD_BLOCK_WRITE);
		rd(s, e); check(s, e);
		$display("test locked done");
		// unlock, then every flash command and a data byte
		set_sel(`SEL_FLASH_CONTROL);
		wr(`UNLOCK_FIRST);
		wr(`UNLOCK_SECOND);
		set_sel(`SEL_FLASH_DATA);
		foreach (cmds[i]) wr(cmds[i]);
		wr(8'($random(seed)));
		$display("test unlocked done");
		// unassigned select reads zero, writes have no effect
		v = 8'($random(seed));
		if (v inside {8'h00, 8'h01, 8'h02, 8'hB4}) v = 8'h5E;
		set_sel(v);
		wr(8'($random(seed)));
		rd(s, e); check(s, e);
		$display("test unmapped done");
		// a whole frame sent while the clock enable is low must leave the select untouched
		repeat (4) @(negedge clk);
		ce = 1'b0;
		host.frame(INSTR_ADDR_WRITE, `SEL_FLASH_CONTROL, s);
		repeat (4) @(negedge clk);
		ce = 1'b1;
		host.frame(INSTR_ADDR_READ, 8'h00, s);
		check(s, sel);
		$display("test enable done");
		// system reset ends programming mode and clears select
		do_reset();
		check({7'h00, pen}, 8'h00);
		host.frame(INSTR_ADDR_READ, 8'h00, s);
		check(s, `SELECT_RESET);
		check(8'(got_q.size()), 8'(exp_q.size()));
		foreach (exp_q[i]) if (i < got_q.size()) check(got_q[i], exp_q[i]);
		$display("test reset done");
		summarize();
	end
endmodule
